// ===== seq_defs.vh
// Purpose: Constants for the radio mode sequencer
// Assumes: 25 MHz core clock
// Notes:   Times in ns; cycle counts derived from the clock period
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// ****************************************
// Clock and timer resolutions
// ****************************************
`define CLK_PERIOD_NS     40
`define STEP_64US_NS      64000
`define STEP_4MS_NS       4100000
`define STEP_262MS_NS     262000000
`define STEP_64US_CYC     (`STEP_64US_NS / `CLK_PERIOD_NS)
`define STEP_4MS_CYC      (`STEP_4MS_NS / `CLK_PERIOD_NS)
`define STEP_262MS_CYC    (`STEP_262MS_NS / `CLK_PERIOD_NS)

// ****************************************
// Step field codes
// ****************************************
`define STEP_OFF          2'h0
`define STEP_64US         2'h1
`define STEP_4MS          2'h2
`define STEP_262MS        2'h3

// ****************************************
// Chip mode codes driven to the mode controller
// ****************************************
`define CHIP_SLEEP        3'h0
`define CHIP_STANDBY      3'h1
`define CHIP_SYNTH        3'h2
`define CHIP_TX           3'h3
`define CHIP_RX           3'h4

// ****************************************
// Selector codes
// ****************************************
`define START_LOWPWR      2'h0
`define START_RX          2'h1
`define START_TX          2'h2
`define START_TX_LEVEL    2'h3
`define RX_HELD_PAYLOAD   3'h1
`define RX_LOWPWR_PAYLOAD 3'h2
`define RX_HELD_CHECK     3'h3
`define RX_OFF_LEVEL      3'h4
`define RX_OFF_PATTERN    3'h5
`define RX_OFF_LEADIN     3'h6
`define TMO_RESTART       2'h0
`define TMO_TX            2'h1
`define TMO_LOWPWR        2'h2
`define TMO_OFF           2'h3
`define HELD_OFF          3'h0
`define HELD_TX_EMPTY     3'h1
`define HELD_LOWPWR       3'h2
`define HELD_RX_SYNTH     3'h3
`define HELD_RX           3'h4

`endif

// ===== interval_timer.v
// Purpose: One interval timer: step-size ticks times a multiplier
// Assumes: start_in is a one-cycle pulse from the same clock
// Notes:   Multiplier zero expires on the cycle after start
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.vh"

module interval_timer #(
  parameter integer MULT_W  = 8,
  parameter integer CYC_64  = `STEP_64US_CYC,
  parameter integer CYC_4   = `STEP_4MS_CYC,
  parameter integer CYC_262 = `STEP_262MS_CYC
) (
  input  wire              core_clk_in,
  input  wire              resetn_in,
  input  wire              start_in,
  input  wire              stop_in,
  input  wire [1:0]        step_in,
  input  wire [MULT_W-1:0] mult_in,
  output reg               expire_out
);

  reg [23:0]       tick_q;
  reg [MULT_W-1:0] left_q;
  reg              run_q;
  reg [23:0]       step_len;

  // Cycles per resolution step
  always @* begin
    case (step_in)
      `STEP_64US: step_len = CYC_64[23:0];
      `STEP_4MS:  step_len = CYC_4[23:0];
      default:    step_len = CYC_262[23:0];
    endcase
  end

  // Count steps down; expire when the last step ends
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_q     <= 24'h000000;
      left_q     <= {MULT_W{1'b0}};
      run_q      <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (stop_in) begin
        run_q <= 1'b0;
        tick_q <= 24'h000000;
      end else if (start_in) begin
        if (step_in == `STEP_OFF) begin
          run_q <= 1'b0;
        end else if (mult_in == {MULT_W{1'b0}}) begin
          expire_out <= 1'b1;
          run_q      <= 1'b0;
        end else begin
          run_q  <= 1'b1;
          tick_q <= step_len - 24'h000001;
          left_q <= mult_in;
        end
      end else if (run_q) begin
        if (tick_q != 24'h000000) begin
          tick_q <= tick_q - 24'h000001;
        end else if (left_q == {{(MULT_W-1){1'b0}}, 1'b1}) begin
          run_q      <= 1'b0;
          expire_out <= 1'b1;
        end else begin
          left_q <= left_q - {{(MULT_W-1){1'b0}}, 1'b1};
          tick_q <= step_len - 24'h000001;
        end
      end
    end
  end

endmodule // interval_timer
`default_nettype wire

// ===== radio_mode_sequencer.v
// Overview of operation
// - Idle holds standby or sleep per choice
// - Start selector picks first step
// - Low-power selection halts or enters idle
// - Record initial mode, restore on halt
// - Idle exits on first timer
// - Transmit exits on frame sent
// - Receive exit selector for payload events
// - Receive halts on level, pattern, lead-in
// - Failed check goes to timeout handling
// - Second timer forces receive to low-power
// - Timeout selector picks receive timeout exit
// - Three wait timeouts form receive timeout
// - Held-frame selector picks next step
// - Two interval timers drive transitions
// - Timers alternate regardless of state
// - Launch only from sleep or standby
// - Idle ignores all but first timer
// - Step codes: off, 64us, 4.1ms, 262ms
//
// Purpose: Autonomous chip-mode sequencer for the transceiver
// Assumes: Events are one-cycle pulses on core_clk_in; settings are static
// Notes:   chip_mode_out feeds the mode controller directly
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.vh"

module radio_mode_sequencer #(
  parameter integer MULT_W  = 8,
  parameter integer CYC_64  = `STEP_64US_CYC,
  parameter integer CYC_4   = `STEP_4MS_CYC,
  parameter integer CYC_262 = `STEP_262MS_CYC
) (
  input  wire              core_clk_in,
  input  wire              resetn_in,
  input  wire              seq_launch_bit_in,
  input  wire              seq_stop_bit_in,
  input  wire [2:0]        chip_mode_in,
  input  wire              idle_low_power_choice_in,
  input  wire [1:0]        start_transition_sel_in,
  input  wire              low_power_target_sel_in,
  input  wire              idle_exit_sel_in,
  input  wire              tx_exit_sel_in,
  input  wire [2:0]        rx_exit_sel_in,
  input  wire [1:0]        rx_timeout_exit_sel_in,
  input  wire [2:0]        pkt_done_exit_sel_in,
  input  wire              check_enable_in,
  input  wire              auto_discard_bad_check_in,
  input  wire [1:0]        first_timer_step_in,
  input  wire [MULT_W-1:0] first_timer_multiplier_in,
  input  wire [1:0]        second_timer_step_in,
  input  wire [MULT_W-1:0] second_timer_multiplier_in,
  input  wire              frame_sent_event_in,
  input  wire              payload_available_event_in,
  input  wire              check_passed_event_in,
  input  wire              signal_level_event_in,
  input  wire              pattern_match_event_in,
  input  wire              lead_in_detect_event_in,
  input  wire              queue_level_event_in,
  input  wire              queue_empty_event_in,
  input  wire              level_wait_timeout_in,
  input  wire              lead_in_wait_timeout_in,
  input  wire              pattern_wait_timeout_in,
  input  wire              synth_locked_in,
  output reg  [2:0]        chip_mode_out,
  output reg               mode_override_out,
  output reg               listen_restart_out,
  output reg  [2:0]        seq_state_out,
  output reg               first_timer_event_out,
  output reg               second_timer_event_out
);

  // ****************************************
  // State codes
  // ****************************************
  localparam [2:0] ST_OFF    = 3'h0; // sequencer_halted_state
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_TX     = 3'h2;
  localparam [2:0] ST_RX     = 3'h3;
  localparam [2:0] ST_HELD   = 3'h4; // frame_held_state
  localparam [2:0] ST_WAITQ  = 3'h5; // waiting for queue level before transmit
  localparam [2:0] ST_SYNTH  = 3'h6; // synth_only_mode before receive

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg        init_standby_q;
  reg        restart_d;
  reg        go_lowpwr;
  reg        go_tmo;
  wire       t1_pulse;
  wire       t2_pulse;
  wire       launch;
  wire       listen_timeout_event;

  // Launch accepted only from a low-power chip mode
  assign launch = seq_launch_bit_in && (state_q == ST_OFF) &&
                  ((chip_mode_in == `CHIP_SLEEP) || (chip_mode_in == `CHIP_STANDBY));

  // Any wait timeout counts as the receive timeout
  assign listen_timeout_event = level_wait_timeout_in | lead_in_wait_timeout_in |
                                pattern_wait_timeout_in;

  // ****************************************
  // Interval timers: T1 from launch or T2, T2 from T1
  // ****************************************
  interval_timer #(
    .MULT_W  (MULT_W),
    .CYC_64  (CYC_64),
    .CYC_4   (CYC_4),
    .CYC_262 (CYC_262)
  ) u_first_timer (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .start_in    (launch | t2_pulse),
    .stop_in     (seq_stop_bit_in),
    .step_in     (first_timer_step_in),
    .mult_in     (first_timer_multiplier_in),
    .expire_out  (t1_pulse)
  );

  interval_timer #(
    .MULT_W  (MULT_W),
    .CYC_64  (CYC_64),
    .CYC_4   (CYC_4),
    .CYC_262 (CYC_262)
  ) u_second_timer (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .start_in    (t1_pulse),
    .stop_in     (seq_stop_bit_in),
    .step_in     (second_timer_step_in),
    .mult_in     (second_timer_multiplier_in),
    .expire_out  (t2_pulse)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always @* begin
    state_d   = state_q;
    restart_d = 1'b0;
    go_lowpwr = 1'b0;
    go_tmo    = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (launch) begin
          case (start_transition_sel_in)
            `START_LOWPWR:   go_lowpwr = 1'b1;
            `START_RX:       state_d = ST_RX;
            `START_TX:       state_d = ST_TX;
            default:         state_d = ST_WAITQ;
          endcase
        end
      end
      ST_WAITQ: begin
        if (queue_level_event_in) state_d = ST_TX;
      end
      ST_IDLE: begin
        // Only the first timer is heard here
        if (t1_pulse) state_d = idle_exit_sel_in ? ST_RX : ST_TX;
      end
      ST_TX: begin
        if (frame_sent_event_in) begin
          if (tx_exit_sel_in) state_d = ST_RX;
          else go_lowpwr = 1'b1;
        end
      end
      ST_RX: begin
        if (t2_pulse) begin
          go_lowpwr = 1'b1;
        end else begin
          case (rx_exit_sel_in)
            `RX_HELD_PAYLOAD:   if (payload_available_event_in) state_d = ST_HELD;
            `RX_LOWPWR_PAYLOAD: if (payload_available_event_in) go_lowpwr = 1'b1;
            `RX_HELD_CHECK: begin
              if (check_passed_event_in) state_d = ST_HELD;
              else if (payload_available_event_in && check_enable_in &&
                       !auto_discard_bad_check_in) go_tmo = 1'b1;
            end
            `RX_OFF_LEVEL:      if (signal_level_event_in) state_d = ST_OFF;
            `RX_OFF_PATTERN:    if (pattern_match_event_in) state_d = ST_OFF;
            `RX_OFF_LEADIN:     if (lead_in_detect_event_in) state_d = ST_OFF;
            default:            state_d = ST_RX;
          endcase
          if (listen_timeout_event) go_tmo = 1'b1;
        end
        if (go_tmo && !go_lowpwr && (state_d == ST_RX)) begin
          case (rx_timeout_exit_sel_in)
            `TMO_RESTART: restart_d = 1'b1;
            `TMO_TX:      state_d = ST_TX;
            `TMO_LOWPWR:  go_lowpwr = 1'b1;
            default:      state_d = ST_OFF;
          endcase
        end
      end
      ST_HELD: begin
        case (pkt_done_exit_sel_in)
          `HELD_OFF:      state_d = ST_OFF;
          `HELD_TX_EMPTY: if (queue_empty_event_in) state_d = ST_TX;
          `HELD_LOWPWR:   go_lowpwr = 1'b1;
          `HELD_RX_SYNTH: state_d = ST_SYNTH;
          `HELD_RX:       state_d = ST_RX;
          default:        state_d = ST_HELD;
        endcase
      end
      ST_SYNTH: begin
        if (synth_locked_in) state_d = ST_RX;
      end
      default: state_d = ST_OFF;
    endcase
    // Low-power selection is transitory
    if (go_lowpwr) state_d = low_power_target_sel_in ? ST_IDLE : ST_OFF;
    // Stop wins over everything but restart_d
    if (seq_stop_bit_in) state_d = ST_OFF;
  end

  // ****************************************
  // State, initial mode and chip-mode outputs
  // ****************************************
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q                <= ST_OFF;
      init_standby_q         <= 1'b0;
      chip_mode_out          <= `CHIP_SLEEP;
      mode_override_out      <= 1'b0;
      listen_restart_out     <= 1'b0;
      seq_state_out          <= ST_OFF;
      first_timer_event_out  <= 1'b0;
      second_timer_event_out <= 1'b0;
    end else begin
      state_q                <= state_d;
      seq_state_out          <= state_d;
      listen_restart_out     <= restart_d;
      first_timer_event_out  <= t1_pulse;
      second_timer_event_out <= t2_pulse;
      if (launch) init_standby_q <= (chip_mode_in == `CHIP_STANDBY);
      mode_override_out <= (state_d != ST_OFF);
      case (state_d)
        ST_IDLE:  chip_mode_out <= idle_low_power_choice_in ? `CHIP_SLEEP
                                                            : `CHIP_STANDBY;
        ST_TX:    chip_mode_out <= `CHIP_TX;
        ST_RX:    chip_mode_out <= `CHIP_RX;
        ST_HELD:  chip_mode_out <= `CHIP_RX;
        ST_SYNTH: chip_mode_out <= `CHIP_SYNTH;
        ST_WAITQ: chip_mode_out <= chip_mode_out;
        default: begin
          // Restore initial low-power mode when halting
          if (state_q != ST_OFF)
            chip_mode_out <= init_standby_q ? `CHIP_STANDBY : `CHIP_SLEEP;
          else
            chip_mode_out <= chip_mode_in;
        end
      endcase
    end
  end

endmodule // radio_mode_sequencer
`default_nettype wire

// ===== seq_monitor.sv
// Purpose: Port checker for the radio mode sequencer
// Assumes: States 0 off, 1 idle, 2 tx, 3 rx
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
  input wire       core_clk_in,
  input wire       resetn_in,
  input wire       seq_launch_bit_in,
  input wire       seq_stop_bit_in,
  input wire [2:0] chip_mode_in,
  input wire       idle_low_power_choice_in,
  input wire [1:0] start_transition_sel_in,
  input wire       low_power_target_sel_in,
  input wire       idle_exit_sel_in,
  input wire       tx_exit_sel_in,
  input wire [2:0] rx_exit_sel_in,
  input wire       frame_sent_event_in,
  input wire       signal_level_event_in,
  input wire [2:0] chip_mode_out,
  input wire       mode_override_out,
  input wire [2:0] seq_state_out,
  input wire       first_timer_event_out,
  input wire       second_timer_event_out
);
  logic [2:0] init_q;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Low-power mode seen at launch, restored on halt
  always @(posedge core_clk_in or negedge resetn_in)
    if (!resetn_in) init_q <= 3'h0;
    else if (seq_state_out == 3'h0 && seq_launch_bit_in && chip_mode_in <= 3'h1)
      init_q <= chip_mode_in;
  // ****
  // Properties
  // ****
  sequence s_launch;
    seq_state_out == 3'h0 && seq_launch_bit_in && !seq_stop_bit_in && chip_mode_in <= 3'h1;
  endsequence
  property p_launch_tx;
    s_launch ##0 start_transition_sel_in == 2'h2 |=>
      seq_state_out == 3'h2 && chip_mode_out == 3'h3 && mode_override_out;
  endproperty
  a_launch_tx: assert property (p_launch_tx) else $error("launch to tx failed");
  property p_idle_mode;
    seq_state_out == 3'h1 |-> chip_mode_out == (idle_low_power_choice_in ? 3'h0 : 3'h1);
  endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("idle chip mode wrong");
  property p_idle_exit;
    first_timer_event_out && $past(seq_state_out) == 3'h1 && !$past(seq_stop_bit_in) |->
      seq_state_out == (idle_exit_sel_in ? 3'h3 : 3'h2);
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");
  property p_idle_hold;
    $past(seq_state_out) == 3'h1 && seq_state_out != 3'h1 && !$past(seq_stop_bit_in) |->
      first_timer_event_out;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without timer");
  property p_tx_rx;
    seq_state_out == 3'h2 && frame_sent_event_in && tx_exit_sel_in && !seq_stop_bit_in |=>
      seq_state_out == 3'h3;
  endproperty
  a_tx_rx: assert property (p_tx_rx) else $error("tx to rx failed");
  property p_rx_t2;
    second_timer_event_out && $past(seq_state_out) == 3'h3 && !$past(seq_stop_bit_in) |->
      seq_state_out == (low_power_target_sel_in ? 3'h1 : 3'h0);
  endproperty
  a_rx_t2: assert property (p_rx_t2) else $error("rx ignored second timer");
  property p_rx_level;
    seq_state_out == 3'h3 && rx_exit_sel_in == 3'h4 && signal_level_event_in &&
      !seq_stop_bit_in && !low_power_target_sel_in |=> seq_state_out == 3'h0;
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level halt failed");
  property p_restore;
    $fell(mode_override_out) && $past(seq_state_out) == 3'h2 && !$past(seq_stop_bit_in) |->
      chip_mode_out == init_q;
  endproperty
  a_restore: assert property (p_restore) else $error("initial mode not restored");
  property p_stop;
    seq_stop_bit_in |=> seq_state_out == 3'h0 && !mode_override_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
endmodule // seq_monitor
bind radio_mode_sequencer seq_monitor mon (.*);
`default_nettype wire

// ===== chip_mode_model.sv
// Purpose: Mode controller standing behind the sequencer
// Assumes: Host keeps the chip in sleep or standby
// Notes:   Synthesiser locks three cycles after entry
`timescale 1ns/1ps
`default_nettype none
module chip_mode_model (
  input  wire logic [2:0] cmd_mode_in,
  input  wire logic       override_in,
  input  wire logic [2:0] host_mode_in,
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  output var  logic [2:0] mode_out,
  output wire logic       locked_out
);
  logic [1:0] lock_q;
  assign locked_out = (lock_q == 2'h3);
  // Chip follows the sequencer while it owns the chip, else the host
  always @(posedge core_clk_in or negedge resetn_in)
    if (!resetn_in) begin
      mode_out <= 3'h1;
      lock_q <= 2'h0;
    end else begin
      mode_out <= override_in ? cmd_mode_in : host_mode_in;
      lock_q <= (mode_out != 3'h2) ? 2'h0 : (locked_out ? lock_q : lock_q + 2'h1);
    end
endmodule // chip_mode_model
`default_nettype wire

// ===== tb_radio_mode_sequencer.sv
// Purpose: Self-checking bench for the radio mode sequencer
// Assumes: Step cycles shortened to 4, 8 and 16
// Notes:   Timers off except in the idle scenario
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.vh"
module tb_radio_mode_sequencer;
  logic core_clk_in = 1'b0, resetn_in = 1'b0, seq_launch_bit_in = 1'b0, seq_stop_bit_in = 1'b0;
  logic idle_low_power_choice_in = 1'b0, low_power_target_sel_in = 1'b0, idle_exit_sel_in = 1'b0;
  logic tx_exit_sel_in = 1'b0, check_enable_in = 1'b0, auto_discard_bad_check_in = 1'b0;
  logic [1:0] start_transition_sel_in = 2'h0, rx_timeout_exit_sel_in = 2'h0;
  logic [1:0] first_timer_step_in = 2'h0, second_timer_step_in = 2'h0;
  logic [2:0] rx_exit_sel_in = 3'h0, pkt_done_exit_sel_in = 3'h0, host_mode = 3'h1;
  logic [7:0] first_timer_multiplier_in = 8'h00, second_timer_multiplier_in = 8'h00;
  logic [10:0] ev = 11'h000;
  wire frame_sent_event_in, payload_available_event_in, check_passed_event_in;
  wire signal_level_event_in, pattern_match_event_in, lead_in_detect_event_in;
  wire queue_level_event_in, queue_empty_event_in, level_wait_timeout_in;
  wire lead_in_wait_timeout_in, pattern_wait_timeout_in, synth_locked_in, mode_override_out;
  wire listen_restart_out, first_timer_event_out, second_timer_event_out;
  wire [2:0] chip_mode_in, chip_mode_out, seq_state_out;
  integer error_cnt = 0, num_checks = 0, seed = 7, cyc = 0, n, i, m1, m2, s2;
  // Event vector fans out to the event pins, bit 0 first
  assign {pattern_wait_timeout_in, lead_in_wait_timeout_in, level_wait_timeout_in,
          queue_empty_event_in, queue_level_event_in, lead_in_detect_event_in,
          pattern_match_event_in, signal_level_event_in, check_passed_event_in,
          payload_available_event_in, frame_sent_event_in} = ev;
  radio_mode_sequencer #(.CYC_64(4), .CYC_4(8), .CYC_262(16)) DUT (.*);
  chip_mode_model partner (.cmd_mode_in(chip_mode_out), .override_in(mode_override_out),
    .host_mode_in(host_mode), .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .mode_out(chip_mode_in), .locked_out(synth_locked_in));
  // Clock and hang guard
  initial forever #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test;
    end
  end
  // ****
  // Helpers
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic fire(input integer idx);
    ev = 11'h001 << idx;
    tick(1);
    ev = 11'h000;
  endtask
  function automatic logic coin();
    coin = ($random(seed) % 2) != 0;
  endfunction
  function automatic logic [2:0] lp_state();
    lp_state = low_power_target_sel_in ? 3'h1 : 3'h0;
  endfunction
  task automatic launch(input integer sel);
    host_mode = {2'h0, coin()};
    tick(2);
    start_transition_sel_in = sel[1:0];
    seq_launch_bit_in = 1'b1;
    tick(1);
    seq_launch_bit_in = 1'b0;
  endtask
  task automatic halt;
    seq_stop_bit_in = 1'b1;
    tick(2);
    seq_stop_bit_in = 1'b0;
    check("halted", 8'(seq_state_out), 8'h00);
  endtask
  task automatic wait_ev(input integer which);
    while ((which ? second_timer_event_out : first_timer_event_out) !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    tick(3);
    resetn_in = 1'b1;
    check("reset", 8'({seq_state_out, mode_override_out, first_timer_event_out}), 8'h00);
    for (i = 0; i < 4; i++) begin
      low_power_target_sel_in = coin();
      idle_low_power_choice_in = coin();
      launch(i);
      if (i == 3) begin
        check("wait level", 8'(seq_state_out), 8'h05);
        fire(6);
      end
      check("start", 8'(seq_state_out), 8'(i == 0 ? lp_state() : (i == 1 ? 3 : 2)));
      if (i == 0 && low_power_target_sel_in)
        check("idle mode", 8'(chip_mode_out), 8'(idle_low_power_choice_in ? 0 : 1));
      halt;
    end
    low_power_target_sel_in = 1'b0;
    for (i = 0; i < 2; i++) begin
      tx_exit_sel_in = i[0];
      launch(2);
      fire(0);
      check("tx exit", 8'(seq_state_out), 8'(i ? 3 : 0));
      if (i == 0)
        check("restored", 8'(chip_mode_out), 8'(host_mode));
      halt;
    end
    for (i = 1; i < 7; i++) begin
      rx_exit_sel_in = i[2:0];
      launch(1);
      fire(0);
      check("rx ignores", 8'(seq_state_out), 8'h03);
      tick(1);
      fire(i < 3 ? 1 : i - 1);
      check("rx exit", 8'(seq_state_out), 8'(i == 1 || i == 3 ? 4 : 0));
      halt;
    end
    rx_exit_sel_in = 3'h3;
    {check_enable_in, rx_timeout_exit_sel_in} = 3'h5;
    launch(1);
    fire(1);
    check("bad check", 8'(seq_state_out), 8'h02);
    halt;
    check_enable_in = 1'b0;
    rx_exit_sel_in = 3'h0;
    for (i = 0; i < 4; i++) begin
      rx_timeout_exit_sel_in = i[1:0];
      launch(1);
      fire(8 + i % 3);
      check("timeout", 8'(seq_state_out), 8'(i == 0 ? 3 : (i == 1 ? 2 : 0)));
      if (i == 0)
        check("restart", 8'(listen_restart_out), 8'h01);
      halt;
    end
    rx_exit_sel_in = 3'h1;
    for (i = 0; i < 5; i++) begin
      pkt_done_exit_sel_in = i[2:0];
      launch(1);
      fire(1);
      tick(8);
      check("held", 8'(seq_state_out), 8'(i == 1 ? 4 : (i > 2 ? 3 : 0)));
      if (i == 1) begin
        fire(7);
        check("held tx", 8'(seq_state_out), 8'h02);
      end
      halt;
    end
    // Timer chain from an idle start, with random counts
    for (i = 0; i < 3; i++) begin
      m1 = 2 + $unsigned($random(seed)) % 3;
      m2 = 1 + $unsigned($random(seed)) % 3;
      s2 = 1 + $unsigned($random(seed)) % 3;
      {first_timer_step_in, second_timer_step_in} = {2'h1, 2'(s2)}; // Both on to cycle
      {first_timer_multiplier_in, second_timer_multiplier_in} = {8'(m1), 8'(m2)};
      {low_power_target_sel_in, idle_exit_sel_in} = {1'b1, (i == 2) ? coin() : i[0]};
      launch(0);
      n = 0;
      check("idle", 8'(seq_state_out), 8'h01);
      // Frame sent and payload pulses while idle must be ignored
      ev = 11'h003;
      tick(2);
      ev = 11'h000;
      n = 2;
      check("idle holds", 8'(seq_state_out), 8'h01);
      wait_ev(0);
      check("t1 delay", 8'(n), 8'(4 * m1 + 1));
      check("idle exit", 8'(seq_state_out), 8'(idle_exit_sel_in ? 3 : 2));
      n = 0;
      wait_ev(1);
      check("t2 delay", 8'(n), 8'((s2 == 3 ? 16 : 4 * s2) * m2 + 1));
      check("after t2", 8'(seq_state_out), 8'(idle_exit_sel_in ? 1 : 2));
      n = 0;
      wait_ev(0);
      check("t1 again", 8'(n), 8'(4 * m1 + 1));
      halt;
    end
    stop_test;
  end
endmodule // tb_radio_mode_sequencer
`default_nettype wire
